// >>> control_bus.sv
`timescale 1ns/100ps
`default_nettype none
module control_bus (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial bus pins
  input wire logic bus_clock,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe,
  input wire logic radio_word_strobe,
  input wire logic synth_word_strobe,
  // Reply sources
  input wire logic lock_detect,
  input wire logic [7:0] poll_result,
  // Radio mode
  output logic sleep,
  output logic restart,
  // Normal command state
  output logic discrim_on,
  output logic [6:0] lock_threshold,
  output logic third_conv_on,
  output logic [7:0] third_level_converter,
  output logic [7:0] dig_out,
  output logic dig_out8,
  output logic lo2_mult_on,
  output logic [7:0] carrier_comparator_converter,
  output logic [7:0] first_level_converter,
  output logic [7:0] second_level_converter,
  output logic read_select_hi,
  output logic read_select_lo,
  // Set-up command state
  output logic [5:0] pll_range,
  output logic [5:0] pll_offset,
  output logic conv3_input_b,
  output logic conv2_input_b,
  output logic clock_multiplier_pll,
  output logic xtal_on,
  output logic bandgap_on,
  output logic [7:0] divisors,
  output logic [7:0] bandgap_trim,
  // Synthesiser word
  output logic [31:0] synth_word,
  output logic [5:0] synth_word_bits,
  output logic synth_word_valid,
  output logic speed_up,
  output logic main_standby_bit,
  output logic aux_standby_bit
);

  // ==========================================
  // Pin synchronisers
  logic [2:0] clk_s;
  logic [1:0] dat_s;
  logic [2:0] rad_s;
  logic [2:0] syn_s;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      clk_s <= 3'h0;
      dat_s <= 2'h0;
      rad_s <= 3'h0;
      syn_s <= 3'h0;
    end else begin
      clk_s <= {clk_s[1:0], bus_clock};
      dat_s <= {dat_s[0], data_in};
      rad_s <= {rad_s[1:0], radio_word_strobe};
      syn_s <= {syn_s[1:0], synth_word_strobe};
    end
  end

  logic bus_rise;
  logic radio_end;
  logic synth_end;
  assign bus_rise = ctl_bus_pkg::rose(clk_s[2], clk_s[1]);
  assign radio_end = ctl_bus_pkg::rose(rad_s[2], rad_s[1]);
  assign synth_end = ctl_bus_pkg::rose(syn_s[2], syn_s[1]);

  // ==========================================
  // Shifter
  shift_link_if link ();
  assign link.bus_rise = bus_rise;
  assign link.data_bit = dat_s[1];

  serial_shifter u_shift (
    .clk(clk),
    .resetn(resetn),
    .word_end(radio_end | synth_end),
    .link(link)
  );

  // ==========================================
  // Radio word decode
  function automatic logic is_type(input logic strobe, input logic [1:0] kind,
                                   input logic [1:0] want);
    is_type = strobe && (kind == want);
  endfunction : is_type

  function automatic logic [14:0] shift_reply(input logic [14:0] sr);
    shift_reply = {sr[13:0], 1'b0};
  endfunction : shift_reply

  logic [7:0] value_byte;
  logic [7:0] command_byte_hi;
  logic [7:0] command_byte_lo;
  logic [1:0] cmd_type;
  logic is_normal;
  logic is_setup;
  logic is_restart;
  assign value_byte = link.word[23:16];
  assign command_byte_hi = link.word[15:8];
  assign command_byte_lo = link.word[7:0];
  assign cmd_type = command_byte_hi[7:6];
  logic is_sleep;
  assign is_normal = is_type(radio_end, cmd_type, ctl_bus_pkg::CMD_NORMAL);
  assign is_setup = is_type(radio_end, cmd_type, ctl_bus_pkg::CMD_SETUP);
  assign is_sleep = is_type(radio_end, cmd_type, ctl_bus_pkg::CMD_SLEEP);
  assign is_restart = is_setup && command_byte_lo[1:0] == 2'h3;

  // ==========================================
  // Mode
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sleep <= ctl_bus_pkg::RST_SLEEP;
      restart <= 1'b0;
    end else begin
      restart <= is_restart;
      // Restart wins over the other types
      if (is_restart) begin
        sleep <= ctl_bus_pkg::RST_SLEEP;
      end else if (is_normal) begin
        sleep <= 1'b0;
      end else if (is_sleep) begin
        sleep <= 1'b1;
      end
    end
  end

  // ==========================================
  // Normal command fields
  always_ff @(posedge clk) begin
    if (!resetn || is_restart) begin
      discrim_on <= 1'b0;
      lock_threshold <= ctl_bus_pkg::RST_FIELD7;
      third_conv_on <= 1'b0;
      third_level_converter <= ctl_bus_pkg::RST_BYTE;
      dig_out <= ctl_bus_pkg::RST_BYTE;
      dig_out8 <= 1'b0;
      lo2_mult_on <= 1'b0;
      carrier_comparator_converter <= ctl_bus_pkg::RST_BYTE;
      first_level_converter <= ctl_bus_pkg::RST_BYTE;
      second_level_converter <= ctl_bus_pkg::RST_BYTE;
      read_select_hi <= 1'b0;
      read_select_lo <= 1'b0;
    end else if (is_normal) begin
      discrim_on <= command_byte_hi[ctl_bus_pkg::HI_DISCRIM];
      third_conv_on <= command_byte_hi[ctl_bus_pkg::HI_CONV3_ON];
      // Load bits act only when set
      if (command_byte_hi[ctl_bus_pkg::HI_LOCK_LD]) begin
        lock_threshold <= value_byte[7:1];
      end
      if (command_byte_hi[ctl_bus_pkg::HI_DOUT_LD]) begin
        dig_out <= value_byte;
      end
      if (command_byte_hi[ctl_bus_pkg::HI_CONV3_LD]) begin
        third_level_converter <= value_byte;
      end
      lo2_mult_on <= command_byte_lo[ctl_bus_pkg::LO_LO2_ON];
      dig_out8 <= command_byte_lo[ctl_bus_pkg::LO_DOUT8];
      if (command_byte_lo[ctl_bus_pkg::LO_COMP_LD]) begin
        carrier_comparator_converter <= value_byte;
      end
      if (command_byte_lo[ctl_bus_pkg::LO_CONV1_LD]) begin
        first_level_converter <= value_byte;
      end
      if (command_byte_lo[ctl_bus_pkg::LO_CONV2_LD]) begin
        second_level_converter <= value_byte;
      end
      read_select_hi <= command_byte_lo[1];
      read_select_lo <= command_byte_lo[0];
    end
  end

  // ==========================================
  // Set-up command fields, kept through sleep
  always_ff @(posedge clk) begin
    if (!resetn || is_restart) begin
      pll_range <= ctl_bus_pkg::RST_FIELD6;
      pll_offset <= ctl_bus_pkg::RST_FIELD6;
      conv3_input_b <= 1'b0;
      conv2_input_b <= 1'b0;
      clock_multiplier_pll <= ctl_bus_pkg::RST_PLL_ON;
      xtal_on <= ctl_bus_pkg::RST_XTAL_ON;
      bandgap_on <= ctl_bus_pkg::RST_BANDGAP_ON;
      divisors <= ctl_bus_pkg::RST_BYTE;
      bandgap_trim <= ctl_bus_pkg::RST_BYTE;
    end else if (is_setup) begin
      if (command_byte_hi[ctl_bus_pkg::SU_RANGE_LD]) begin
        pll_range <= value_byte[5:0];
      end
      if (command_byte_hi[ctl_bus_pkg::SU_OFFSET_LD]) begin
        pll_offset <= value_byte[5:0];
      end
      conv3_input_b <= command_byte_hi[ctl_bus_pkg::SU_CONV3_B];
      conv2_input_b <= command_byte_hi[ctl_bus_pkg::SU_CONV2_B];
      clock_multiplier_pll <= command_byte_hi[ctl_bus_pkg::SU_PLL_ON];
      xtal_on <= command_byte_lo[ctl_bus_pkg::SU_XTAL_ON];
      bandgap_on <= command_byte_lo[ctl_bus_pkg::SU_BANDGAP_ON];
      if (command_byte_lo[ctl_bus_pkg::SU_DIV_LD]) begin
        divisors <= value_byte;
      end
      if (command_byte_lo[ctl_bus_pkg::SU_TRIM_LD]) begin
        bandgap_trim <= value_byte;
      end
    end
  end

  // ==========================================
  // Synthesiser word
  always_ff @(posedge clk) begin
    if (!resetn) begin
      synth_word <= 32'h00000000;
      synth_word_bits <= 6'h00;
      synth_word_valid <= 1'b0;
      speed_up <= 1'b0;
      main_standby_bit <= 1'b0;
      aux_standby_bit <= 1'b0;
    end else begin
      synth_word_valid <= synth_end;
      speed_up <= syn_s[1];
      if (synth_end) begin
        synth_word <= link.word;
        synth_word_bits <= link.bit_count;
        // Standby flags only from a standby word
        if (link.word[1:0] == ctl_bus_pkg::SYN_STANDBY_TYPE) begin
          main_standby_bit <= link.word[ctl_bus_pkg::SYN_MAIN_SB];
          aux_standby_bit <= link.word[ctl_bus_pkg::SYN_AUX_SB];
        end
      end
    end
  end

  // ==========================================
  // Reply transmitter
  ctl_bus_pkg::reply_state_t state;
  logic [5:0] edge_cnt;
  logic [4:0] bits_left;
  logic [14:0] reply_sr;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= ctl_bus_pkg::ST_IDLE;
      edge_cnt <= 6'h00;
      bits_left <= 5'h00;
      reply_sr <= 15'h0000;
      data_out <= 1'b0;
      data_oe <= 1'b0;
    end else begin
      case (state)
        ctl_bus_pkg::ST_IDLE: begin
          data_oe <= 1'b0;
          if (is_normal) begin
            state <= ctl_bus_pkg::ST_WAIT;
            edge_cnt <= 6'h00;
            reply_sr <= {ctl_bus_pkg::REPLY_HEADER, command_byte_lo[1:0],
                         lock_detect, poll_result};
          end
        end
        ctl_bus_pkg::ST_WAIT: begin
          if (bus_rise) begin
            edge_cnt <= edge_cnt + 6'h01;
            // Fifth bus edge after the strobe
            if (edge_cnt == ctl_bus_pkg::REPLY_EDGE - 6'h01) begin
              data_out <= reply_sr[14];
              data_oe <= 1'b1;
              reply_sr <= shift_reply(reply_sr);
              bits_left <= ctl_bus_pkg::REPLY_BITS - 5'h01;
              state <= ctl_bus_pkg::ST_SEND;
            end
          end
        end
        ctl_bus_pkg::ST_SEND: begin
          if (bus_rise) begin
            if (bits_left == 5'h00) begin
              data_oe <= 1'b0;
              data_out <= 1'b0;
              state <= ctl_bus_pkg::ST_IDLE;
            end else begin
              data_out <= reply_sr[14];
              reply_sr <= shift_reply(reply_sr);
              bits_left <= bits_left - 5'h01;
            end
          end
        end
        default: begin
          state <= ctl_bus_pkg::ST_IDLE;
          data_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule : control_bus
`default_nettype wire

// >>> control_bus_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Port checker
module control_bus_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bus pins
  input wire logic bus_clock,
  input wire logic data_in,
  input wire logic data_oe,
  input wire logic radio_word_strobe,
  input wire logic synth_word_strobe,
  // Watched outputs
  input wire logic sleep,
  input wire logic restart,
  input wire logic [7:0] dig_out,
  input wire logic dig_out8,
  input wire logic [7:0] bandgap_trim,
  input wire logic [31:0] synth_word,
  input wire logic synth_word_valid,
  input wire logic speed_up
);
  logic [2:0] q;
  logic [23:0] sh;
  logic [23:0] w;
  logic [23:0] sw;
  logic [4:0] rcnt;
  always_ff @(posedge clk) begin
    q <= {bus_clock, radio_word_strobe, synth_word_strobe};
    if (bus_clock & ~q[2]) sh <= {sh[22:0], data_in};
  end
  always_ff @(posedge clk) begin
    if (radio_word_strobe & ~q[1]) w <= sh;
    if (synth_word_strobe & ~q[0]) sw <= sh;
  end
  // Bus rises since the radio strobe rose
  always_ff @(posedge clk) begin
    if (!resetn) rcnt <= 5'h1F;
    else if (radio_word_strobe & ~q[1]) rcnt <= 5'h00;
    else if (bus_clock & ~q[2] & (rcnt != 5'h1F)) rcnt <= rcnt + 5'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  reply_start_a: assert property ($rose(data_oe) |-> rcnt == 5'h05)
    else $error("reply began on wrong bus edge");
  reply_stop_a: assert property ($fell(data_oe) |-> rcnt == 5'h14)
    else $error("reply length wrong");
  oe_normal_a: assert property (data_oe |-> w[15:14] == 2'h1)
    else $error("line driven outside normal reply");
  sleep_exit_a: assert property ($fell(sleep) |-> w[15:14] == 2'h1)
    else $error("sleep left without normal command");
  sleep_enter_a: assert property ($rose(sleep) |-> w[15:14] == 2'h0 || restart)
    else $error("sleep entered wrongly");
  restart_pulse_a: assert property (restart |-> w[15:14] == 2'h2 && w[1:0] == 2'h3 ##1 !restart)
    else $error("restart pulse wrong");
  dout_load_a: assert property ($changed(dig_out) |-> restart || $past(restart) ||
    (w[15:14] == 2'h1 && w[10] && dig_out == w[23:16]))
    else $error("digital outputs loaded wrongly");
  dout8_set_a: assert property ($changed(dig_out8) |-> restart || $past(restart) ||
    (w[15:14] == 2'h1 && dig_out8 == w[5]))
    else $error("output 8 set wrongly");
  trim_load_a: assert property ($changed(bandgap_trim) |-> restart || $past(restart) ||
    (w[15:14] == 2'h2 && w[4] && bandgap_trim == w[23:16]))
    else $error("bandgap trim loaded wrongly");
  synth_take_a: assert property (synth_word_valid |-> synth_word[23:0] == sw)
    else $error("synth word wrong");
  speed_on_a: assert property ($rose(synth_word_strobe) |-> ##[1:5] speed_up)
    else $error("speed-up did not follow strobe");
endmodule : control_bus_chk
bind control_bus control_bus_chk chk_i (.clk, .resetn, .bus_clock, .data_in, .data_oe,
  .radio_word_strobe, .synth_word_strobe, .sleep, .restart, .dig_out, .dig_out8,
  .bandgap_trim, .synth_word, .synth_word_valid, .speed_up);
`default_nettype wire

// >>> ctl_bus_pkg.sv
package ctl_bus_pkg;

  localparam int WORD_BITS = 24;
  localparam int LONG_BITS = 32;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] REPLY_EDGE = 6'h05;
  localparam logic [4:0] REPLY_BITS = 5'h0F;
  localparam logic [3:0] REPLY_HEADER = 4'hA;

  // Command types, high byte bits 7:6
  localparam logic [1:0] CMD_SLEEP = 2'h0;
  localparam logic [1:0] CMD_NORMAL = 2'h1;
  localparam logic [1:0] CMD_SETUP = 2'h2;
  localparam logic [1:0] CMD_TEST = 2'h3;

  // Bit positions in the command bytes
  localparam int HI_DISCRIM = 5;
  localparam int HI_LOCK_LD = 4;
  localparam int HI_CONV3_ON = 3;
  localparam int HI_DOUT_LD = 2;
  localparam int HI_CONV3_LD = 1;
  localparam int LO_LO2_ON = 6;
  localparam int LO_DOUT8 = 5;
  localparam int LO_COMP_LD = 4;
  localparam int LO_CONV1_LD = 3;
  localparam int LO_CONV2_LD = 2;
  localparam int SU_RANGE_LD = 4;
  localparam int SU_OFFSET_LD = 3;
  localparam int SU_CONV3_B = 2;
  localparam int SU_CONV2_B = 1;
  localparam int SU_PLL_ON = 0;
  localparam int SU_XTAL_ON = 7;
  localparam int SU_BANDGAP_ON = 6;
  localparam int SU_DIV_LD = 5;
  localparam int SU_TRIM_LD = 4;

  // Synth standby word: type in bits 1:0, standby flags above
  localparam logic [1:0] SYN_STANDBY_TYPE = 2'h2;
  localparam int SYN_MAIN_SB = 2;
  localparam int SYN_AUX_SB = 3;

  // Values after reset or restart
  localparam logic RST_SLEEP = 1'b1;
  localparam logic RST_XTAL_ON = 1'b1;
  localparam logic RST_PLL_ON = 1'b1;
  localparam logic RST_BANDGAP_ON = 1'b1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_FIELD6 = 6'h00;
  localparam logic [6:0] RST_FIELD7 = 7'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SEND = 3'b100
  } reply_state_t;

  function automatic logic rose(input logic prev, input logic cur);
    rose = cur & ~prev;
  endfunction : rose

endpackage : ctl_bus_pkg

// >>> ctl_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Controller on the serial bus
module ctl_host_model (
  // Clock and reply pins
  input wire logic clk,
  input wire logic data_oe,
  input wire logic data_out,
  // Bus pins
  output logic bus_clock,
  output wire logic data_line,
  output logic radio_word_strobe,
  output logic synth_word_strobe
);
  logic drv = 1'b0;
  logic md = 1'b0;
  logic junk = 1'b0;
  initial begin
    bus_clock = 1'b0;
    radio_word_strobe = 1'b0;
    synth_word_strobe = 1'b0;
  end
  // Released line shows a changing pattern
  always @(posedge clk) junk <= ~junk;
  assign data_line = (data_oe === 1'b1) ? data_out : (drv ? md : junk);
  task automatic half(input logic lvl);
    bus_clock = lvl;
    #62.5;
  endtask : half
  task automatic send(input logic [31:0] w, input int n, input logic syn, input int hold);
    @(posedge clk);
    #2;
    repeat (8) begin
      half(1'b0);
      half(1'b1);
    end
    drv = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      md = w[i];
      half(1'b0);
      half(1'b1);
    end
    drv = 1'b0;
    bus_clock = 1'b0;
    #30;
    if (syn) synth_word_strobe = 1'b1;
    else radio_word_strobe = 1'b1;
    #32.5;
    half(1'b1);
    for (int i = 0; i < 24; i++) begin
      bus_clock = 1'b0;
      #30;
      if (i == hold) begin
        radio_word_strobe = 1'b0;
        synth_word_strobe = 1'b0;
      end
      #32.5;
      half(1'b1);
    end
    bus_clock = 1'b0;
  endtask : send
endmodule : ctl_host_model
`default_nettype wire

// >>> serial_shifter.sv
`timescale 1ns/100ps
`default_nettype none
module serial_shifter (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Word boundary
  input wire logic word_end,
  // Link to decoder
  shift_link_if.shifter link
);

  // ==========================================
  // Shift register, MSB first
  always_ff @(posedge clk) begin
    if (!resetn) begin
      link.word <= 32'h00000000;
    end else if (link.bus_rise) begin
      link.word <= {link.word[30:0], link.data_bit};
    end
  end

  // ==========================================
  // Bits since the last strobe, saturating
  always_ff @(posedge clk) begin
    if (!resetn) begin
      link.bit_count <= 6'h00;
    end else if (word_end) begin
      link.bit_count <= 6'h00;
    end else if (link.bus_rise && link.bit_count != 6'h3F) begin
      link.bit_count <= link.bit_count + 6'h01;
    end
  end

endmodule : serial_shifter
`default_nettype wire

// >>> shift_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface shift_link_if;
  logic bus_rise;
  logic data_bit;
  logic [31:0] word;
  logic [5:0] bit_count;

  modport shifter (
    input bus_rise,
    input data_bit,
    output word,
    output bit_count
  );
  modport decoder (
    output bus_rise,
    output data_bit,
    input word,
    input bit_count
  );
endinterface : shift_link_if
`default_nettype wire

// >>> test_radio_synth_serial_control_bus.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Bench for the serial control bus
module test_radio_synth_serial_control_bus;
  logic clk = 1'b0, resetn = 1'b0, lock_detect = 1'b0;
  logic [7:0] poll_result = 8'h00;
  wire logic bus_clock, data_line, radio_word_strobe, synth_word_strobe;
  logic data_out, data_oe, sleep, restart, discrim_on, dig_out8, lo2_mult_on;
  logic read_select_hi, read_select_lo, clock_multiplier_pll, xtal_on;
  logic third_conv_on, conv3_input_b, conv2_input_b, bandgap_on;
  logic synth_word_valid, speed_up, main_standby_bit, aux_standby_bit;
  logic [6:0] lock_threshold;
  logic [7:0] dig_out, carrier_comparator_converter, first_level_converter;
  logic [7:0] second_level_converter, bandgap_trim, third_level_converter, divisors;
  logic [5:0] pll_range, pll_offset, synth_word_bits;
  logic [31:0] synth_word, v;
  logic [14:0] rq[$];
  logic [31:0] sq[$], mq[$];
  integer seed = 32'h2E64;
  int num_errors = 0, check_count = 0;
  always #5 clk = ~clk;
  ctl_host_model host (.clk, .data_oe, .data_out, .bus_clock, .data_line,
    .radio_word_strobe, .synth_word_strobe);
  control_bus uut (.clk, .resetn, .bus_clock, .data_in(data_line), .data_out, .data_oe,
    .radio_word_strobe, .synth_word_strobe, .lock_detect, .poll_result, .sleep, .restart,
    .discrim_on, .lock_threshold, .third_conv_on, .third_level_converter, .dig_out,
    .dig_out8, .lo2_mult_on, .carrier_comparator_converter, .first_level_converter,
    .second_level_converter, .read_select_hi, .read_select_lo, .pll_range, .pll_offset,
    .conv3_input_b, .conv2_input_b, .clock_multiplier_pll, .xtal_on, .bandgap_on,
    .divisors, .bandgap_trim, .synth_word, .synth_word_bits, .synth_word_valid,
    .speed_up, .main_standby_bit, .aux_standby_bit);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic radio(input logic [23:0] w);
    logic [31:0] r;
    r = $random(seed);
    @(posedge clk);
    lock_detect <= r[8];
    poll_result <= r[7:0];
    @(posedge clk);
    if (w[15:14] == 2'h1) rq.push_back({4'hA, w[1:0], lock_detect, poll_result});
    host.send({8'h00, w}, 24, 1'b0, 2);
    repeat (4) @(posedge clk);
  endtask : radio
  task automatic synth(input logic [31:0] w, input int n, input int hold);
    sq.push_back(w);
    mq.push_back(n == 32 ? 32'hFFFFFFFF : 32'h00FFFFFF);
    host.send(w, n, 1'b1, hold);
    repeat (4) @(posedge clk);
    chk("synth_bits", (n + 33 > 63) ? 63 : n + 33, synth_word_bits);
  endtask : synth
  always @(posedge clk) begin
    if (synth_word_valid === 1'b1) begin
      chk("synth_word", sq[0] & mq[0], synth_word & mq[0]);
      void'(sq.pop_front());
      void'(mq.pop_front());
    end
  end
  initial forever begin : reply_watch
    logic [14:0] r;
    @(posedge data_oe);
    for (int i = 0; i < 15; i++) begin
      @(negedge bus_clock);
      r = {r[13:0], data_line};
    end
    if (rq.size() == 0) chk("reply_count", 0, 1);
    else chk("reply", rq.pop_front(), r);
  end
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("sleep", 1, sleep);
    chk("xtal_on", 1, xtal_on);
    for (int y = 0; y < 4; y++) begin
      v = $random(seed);
      radio({v[7:0], 8'h7E, 2'h1, y[0], 3'h7, y[1:0]});
      chk("third_on", 1, third_conv_on);
      chk("third", v[7:0], third_level_converter);
      chk("sleep", 0, sleep);
      chk("dig_out", v[7:0], dig_out);
      chk("lock_threshold", v[7:1], lock_threshold);
      chk("discrim_on", 1, discrim_on);
      chk("carrier", v[7:0], carrier_comparator_converter);
      chk("second", v[7:0], second_level_converter);
      chk("dout8", y[0], dig_out8);
      chk("select", y[1:0], {read_select_hi, read_select_lo});
    end
    radio({8'h28, 8'h40, 8'h00});
    chk("dig_out", v[7:0], dig_out);
    chk("first", v[7:0], first_level_converter);
    chk("lo2_on", 0, lo2_mult_on);
    chk("third_on", 0, third_conv_on);
    chk("third", v[7:0], third_level_converter);
    v = $random(seed);
    radio({v[7:0], 8'h9E, 8'h70});
    chk("pll_range", v[5:0], pll_range);
    chk("pll_offset", v[5:0], pll_offset);
    chk("pll_on", 0, clock_multiplier_pll);
    chk("trim", v[7:0], bandgap_trim);
    chk("conv_b", 3, {conv3_input_b, conv2_input_b});
    chk("xtal_on", 0, xtal_on);
    chk("bandgap_on", 1, bandgap_on);
    chk("divisors", v[7:0], divisors);
    radio({8'h28, 8'h00, 8'h00});
    chk("sleep", 1, sleep);
    radio({8'h28, 8'h3F, 8'hFC});
    chk("trim", v[7:0], bandgap_trim);
    radio({8'h28, 8'h40, 8'h00});
    chk("sleep", 0, sleep);
    radio({8'h28, 8'h80, 8'h03});
    chk("sleep", 1, sleep);
    chk("trim", 0, bandgap_trim);
    chk("xtal_on", 1, xtal_on);
    for (int k = 0; k < 4; k++) begin
      v = $random(seed);
      synth({8'h00, v[23:4], k[1:0], 2'h2}, 24, 3);
      chk("main_sb", k[0], main_standby_bit);
      chk("aux_sb", k[1], aux_standby_bit);
    end
    v = $random(seed);
    synth({v[31:2], 2'h1}, 32, 20);
    chk("aux_sb", 1, aux_standby_bit);
    chk("speed_up", 0, speed_up);
    chk("replies", 0, rq.size());
    tally_and_finish();
  end
endmodule : test_radio_synth_serial_control_bus
`default_nettype wire
